//--- hdl/pws_regs.vh
// register offsets, field positions, reset values and timing counts for the pll wrapper
// assumes inclusion by its bare name from the wrapper module
`ifndef PWS_REGS_VH
`define PWS_REGS_VH

// ----------------------------------------
// register indices; the byte address is four times the index
// ----------------------------------------
`define PWS_STATUS_IDX 4'h0
`define PWS_CONTROL_IDX 4'h1
`define PWS_IRQ_STATUS_IDX 4'h2
`define PWS_IRQ_ENABLE_IDX 4'h3
`define PWS_IRQ_CLEAR_IDX 4'h4
`define PWS_CONFIG_IDX 4'h5

// ----------------------------------------
// field positions
// ----------------------------------------
`define PWS_ST_LOCK_BIT 0
`define PWS_ST_PDONE_BIT 1
`define PWS_CT_LOOP_RST_BIT 0
`define PWS_CT_DET_EN_BIT 1
`define PWS_IRQ_LOCK_GAIN_BIT 0
`define PWS_IRQ_LOCK_LOSS_BIT 1
`define PWS_IRQ_PDONE_BIT 2
`define PWS_CFG_RST_REG_BIT 0
`define PWS_CFG_EN_REG_BIT 1
`define PWS_CFG_PDONE_REG_BIT 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define PWS_CT_RESET 2'h2
`define PWS_CT_LOOP_RST_RESET 1'b0
`define PWS_CT_DET_EN_RESET 1'b1
`define PWS_IRQ_EN_RESET 3'h0
`define PWS_CFG_RESET 3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define PWS_CLK_PERIOD_NS 5
`define PWS_LOOP_RST_NS 1000
`define PWS_LOOP_RST_CYC ((`PWS_LOOP_RST_NS + `PWS_CLK_PERIOD_NS - 1) / `PWS_CLK_PERIOD_NS)

// ----------------------------------------
// axi responses
// ----------------------------------------
`define PWS_RESP_OKAY 2'h0
`define PWS_RESP_SLVERR 2'h2

`endif

//--- hdl/pws_pll_wrapper.v
// pll wrapper: reset sequencing, status/control bits over axi4-lite, interrupt
// assumes the loop itself is outside; its lock and phase-done come in asynchronously
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
module pws_pll_wrapper (
   // clock, reset, enable
   input wire aclk,
   input wire aresetn,
   input wire clk_en,
   // axi4-lite write address
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // loop side
   input wire loop_locked_async,
   input wire loop_phase_done_async,
   output reg loop_reset_q,
   output reg loop_enable_q,
   output reg det_enable_q,
   // exported pins
   input wire ext_loop_reset,
   input wire ext_loop_enable,
   output reg lock_out_q,
   output reg phase_done_out_q,
   output reg sys_reset_n_q,
   output reg irq_q
);
`include "pws_regs.vh"

   localparam [1:0] ST_CFG_RST = 2'h0;
   localparam [1:0] ST_WAIT_LOCK = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;
   localparam [31:0] RST_CYC_FULL = `PWS_LOOP_RST_CYC;
   localparam [15:0] RST_CYC = RST_CYC_FULL[15:0];

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   reg [1:0] lock_sync_q;
   reg [1:0] pdone_sync_q;
   reg [1:0] xrst_sync_q;
   reg [1:0] xen_sync_q;
   reg lock_prev_q;
   reg pdone_prev_q;

   // every loop and pin input is foreign to aclk; only the second stage is read
   always @(posedge aclk) begin
      if (!aresetn) begin
         lock_sync_q <= 2'h0;
         pdone_sync_q <= 2'h0;
         xrst_sync_q <= 2'h0;
         xen_sync_q <= 2'h3;
         lock_prev_q <= 1'b0;
         pdone_prev_q <= 1'b0;
      end else if (clk_en) begin
         lock_sync_q <= {lock_sync_q[0], loop_locked_async};
         pdone_sync_q <= {pdone_sync_q[0], loop_phase_done_async};
         xrst_sync_q <= {xrst_sync_q[0], ext_loop_reset};
         xen_sync_q <= {xen_sync_q[0], ext_loop_enable};
         lock_prev_q <= lock_sync_q[1];
         pdone_prev_q <= pdone_sync_q[1];
      end
   end

   wire lock_s = lock_sync_q[1];
   wire pdone_s = pdone_sync_q[1];

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg ctl_rst_q;
   reg ctl_det_q;
   reg [2:0] cfg_q;
   reg [2:0] irq_st_q;
   reg [2:0] irq_en_q;
   reg [1:0] seq_q;
   reg [15:0] cnt_q;

   // a register-mapped reset input ignores the pin; an exported one ignores the bit
   wire rst_by_reg = cfg_q[`PWS_CFG_RST_REG_BIT];
   wire rst_req = rst_by_reg ? ctl_rst_q : xrst_sync_q[1];

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   reg aw_got_q;
   reg w_got_q;
   reg [3:0] aw_idx_q;
   reg aw_ok_q;
   reg [31:0] wdata_q;
   reg wlane0_q;

   // byte address is four times the index; anything beyond the map answers slverr
   function [4:0] dec;
      input [31:0] a;
      begin
         dec = {(a[31:5] == 27'h0) && (a[4:2] <= 3'h5), a[5:2]};
      end
   endfunction

   wire [4:0] awd = dec(s_axi_awaddr);
   wire [4:0] ard = dec(s_axi_araddr);
   // a write lands once, in the cycle its response is raised
   wire do_write = aw_got_q && w_got_q && !s_axi_bvalid;
   wire wr_ok = do_write && aw_ok_q && wlane0_q;

   reg [31:0] rd_val;
   always @* begin
      rd_val = 32'h0;
      case (ard[3:0])
         `PWS_STATUS_IDX: rd_val = {30'h0, pdone_s, lock_s};
         `PWS_CONTROL_IDX: rd_val = {30'h0, ctl_det_q, ctl_rst_q};
         `PWS_IRQ_STATUS_IDX: rd_val = {29'h0, irq_st_q};
         `PWS_IRQ_ENABLE_IDX: rd_val = {29'h0, irq_en_q};
         `PWS_CONFIG_IDX: rd_val = {29'h0, cfg_q};
         default: rd_val = 32'h0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PWS_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `PWS_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_idx_q <= 4'h0;
         aw_ok_q <= 1'b0;
         wdata_q <= 32'h0;
         wlane0_q <= 1'b0;
      end else if (clk_en) begin
         // readies idle on alternate cycles: costs throughput, keeps every ready registered
         s_axi_awready <= !aw_got_q && !s_axi_awready;
         s_axi_wready <= !w_got_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_idx_q <= awd[3:0];
            aw_ok_q <= awd[4];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wlane0_q <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_ok_q ? `PWS_RESP_OKAY : `PWS_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
         end
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= ard[4] ? rd_val : 32'h0;
            s_axi_rresp <= ard[4] ? `PWS_RESP_OKAY : `PWS_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // control, config and interrupt registers
   // ----------------------------------------
   wire [2:0] irq_ev = {pdone_s & ~pdone_prev_q, ~lock_s & lock_prev_q, lock_s & ~lock_prev_q};
   wire [2:0] irq_clr = (wr_ok && aw_idx_q == `PWS_IRQ_CLEAR_IDX) ? wdata_q[2:0] : 3'h0;

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctl_rst_q <= `PWS_CT_LOOP_RST_RESET;
         ctl_det_q <= `PWS_CT_DET_EN_RESET;
         cfg_q <= `PWS_CFG_RESET;
         irq_st_q <= 3'h0;
         irq_en_q <= `PWS_IRQ_EN_RESET;
      end else if (clk_en) begin
         // the reset bit self-clears once the loop reset has been issued
         if (wr_ok && aw_idx_q == `PWS_CONTROL_IDX) begin
            ctl_rst_q <= wdata_q[`PWS_CT_LOOP_RST_BIT];
            ctl_det_q <= wdata_q[`PWS_CT_DET_EN_BIT];
         end else if (seq_q == ST_CFG_RST && cnt_q == RST_CYC) begin
            ctl_rst_q <= 1'b0;
         end
         if (wr_ok && aw_idx_q == `PWS_CONFIG_IDX)
            cfg_q <= wdata_q[2:0];
         if (wr_ok && aw_idx_q == `PWS_IRQ_ENABLE_IDX)
            irq_en_q <= wdata_q[2:0];
         // a new event wins over a clear in the same cycle
         irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
      end
   end

   // ----------------------------------------
   // reset sequencer
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         seq_q <= ST_CFG_RST;
         cnt_q <= 16'h0;
      end else if (clk_en) begin
         // the pulse is counted from entry, so even a one-cycle request gets its full length
         case (seq_q)
            ST_CFG_RST: begin
               if (cnt_q == RST_CYC) begin
                  seq_q <= ST_WAIT_LOCK;
                  cnt_q <= 16'h0;
               end else begin
                  cnt_q <= cnt_q + 16'h1;
               end
            end
            ST_WAIT_LOCK: begin
               // a request while waiting for lock restarts the whole pulse
               if (rst_req) begin
                  seq_q <= ST_CFG_RST;
               end else if (lock_s) begin
                  seq_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (rst_req) begin
                  seq_q <= ST_CFG_RST;
                  cnt_q <= 16'h0;
               end else if (!lock_s) begin
                  // output clocks are unreliable once lock is lost, so hold the system
                  seq_q <= ST_WAIT_LOCK;
               end
            end
            default: seq_q <= ST_CFG_RST;
         endcase
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         loop_reset_q <= 1'b1;
         loop_enable_q <= 1'b1;
         det_enable_q <= 1'b1;
         lock_out_q <= 1'b0;
         phase_done_out_q <= 1'b0;
         sys_reset_n_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (clk_en) begin
         loop_reset_q <= (seq_q == ST_CFG_RST) || rst_req;
         loop_enable_q <= cfg_q[`PWS_CFG_EN_REG_BIT] ? 1'b1 : xen_sync_q[1];
         det_enable_q <= ctl_det_q;
         lock_out_q <= lock_s;
         phase_done_out_q <= cfg_q[`PWS_CFG_PDONE_REG_BIT] ? 1'b0 : pdone_s;
         // release needs run state, lock and no pending request all at once
         sys_reset_n_q <= (seq_q == ST_RUN) && lock_s && !rst_req;
         // irq follows the next status so it rises with the event, not a cycle later
         irq_q <= |(((irq_st_q & ~irq_clr) | irq_ev) & irq_en_q);
      end
   end
   // clocks from the loop bypass this module; internal ones may clock logic
endmodule

//--- test/pws_pll_chk.sv
// checker: reset sequencing, lock and read-answer relations of the pll wrapper
// assumes it is bound to pws_pll_wrapper and sees only its ports
module pws_pll_chk (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // read request
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   // loop side
   input wire loop_locked_async,
   input wire loop_reset_q,
   input wire loop_enable_q,
   input wire det_enable_q,
   // exported
   input wire lock_out_q,
   input wire sys_reset_n_q
);
   timeunit 1ns;
   timeprecision 100ps;
`include "pws_regs.vh"
   localparam int RST_CYC = `PWS_LOOP_RST_CYC;
   int cnt_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------
   // loop reset length
   // ----------------
   always @(posedge aclk) begin
      if (!aresetn || !loop_reset_q) begin
         cnt_q <= 0;
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end
   sequence s_lock_hi;
      loop_locked_async [*5];
   endsequence
   sequence s_lock_lo;
      (!loop_locked_async) [*5];
   endsequence
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // ----------------
   // assertions
   // ----------------
   AST_RST_LEN: assert property ($fell(loop_reset_q) |-> cnt_q >= RST_CYC)
      else $error("loop reset pulse too short");
   AST_SYS_RISE: assert property ($rose(sys_reset_n_q) |-> lock_out_q && !loop_reset_q)
      else $error("system reset released without lock");
   AST_LOOP_RST_SYS: assert property (loop_reset_q [*4] |-> !sys_reset_n_q)
      else $error("loop reset did not hold the system");
   AST_LOCK_HI: assert property (s_lock_hi |-> lock_out_q)
      else $error("lock output stayed low");
   AST_LOCK_LO: assert property (s_lock_lo |-> !lock_out_q)
      else $error("lock output stayed high");
   AST_LOSS_SYS: assert property ((!lock_out_q) [*4] |-> !sys_reset_n_q)
      else $error("system out of reset while unlocked");
   AST_BOOT_EN: assert property ($rose(aresetn) |-> det_enable_q && loop_enable_q)
      else $error("enables not set after reset");
   AST_RD_ANSWER: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
endmodule
bind pws_pll_wrapper pws_pll_chk u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .loop_locked_async, .loop_reset_q, .loop_enable_q, .det_enable_q,
   .lock_out_q, .sys_reset_n_q);

//--- test/pws_loop_model.sv
// loop model: reports lock a fixed time after reset ends while enabled
// assumes the bench clock; drop forces a loss of lock
module pws_loop_model #(
   parameter int LOCK_CYC = 20
) (
   // clock
   input wire aclk,
   // controls from the wrapper and bench
   input wire loop_reset_q,
   input wire loop_enable_q,
   input wire drop,
   // status
   output wire loop_locked_async
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;
   always @(posedge aclk) begin
      if (loop_reset_q || !loop_enable_q || drop) begin
         cnt <= 0;
      end else if (cnt < LOCK_CYC) begin
         cnt <= cnt + 1;
      end
   end
   assign loop_locked_async = (cnt == LOCK_CYC);
endmodule

//--- test/pws_pll_wrapper_bench.sv
// bench: drives the wrapper over axi4-lite and its pins, judges every read answer and two write answers
// assumes the loop model on the loop side and a 200 MHz clock
module pws_pll_wrapper_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, loop_phase_done_async, ext_loop_reset;
   logic ext_loop_enable, drop;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rq;
   logic [3:0] s_axi_wstrb;
   logic [1:0] rr;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire loop_locked_async, loop_reset_q, loop_enable_q, det_enable_q, lock_out_q;
   wire phase_done_out_q, sys_reset_n_q, irq_q;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int bad_count = 0;
   int cmp_count = 0;
   pws_pll_wrapper u_dut (.*);
   pws_loop_model u_loop (.aclk(aclk), .loop_reset_q(loop_reset_q),
      .loop_enable_q(loop_enable_q), .drop(drop), .loop_locked_async(loop_locked_async));
   initial begin
      aclk = 0;
      forever #2.5 aclk = ~aclk;
   end
   // ----------------
   // helpers
   // ----------------
   task results();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask
   task wait_sys();
      int n;
      for (n = 0; n < 600 && sys_reset_n_q !== 1'b1; n++) @(negedge aclk);
      if (sys_reset_n_q !== 1'b1) begin
         bad_count++;
         results();
      end
   endtask
   // one transfer; ready and valid are judged at the falling edge, changes follow the rising one
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      logic pa, pw, pb, ta, tw, tb;
      @(posedge aclk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1;
         s_axi_wvalid <= 1;
         s_axi_bready <= 1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1;
         s_axi_rready <= 1;
      end
      pa = 1;
      pw = w;
      pb = 1;
      for (n = 0; n < 60 && pb; n++) begin
         @(negedge aclk);
         ta = pa && (w ? s_axi_awready : s_axi_arready);
         tw = pw && s_axi_wready;
         tb = !pa && !pw && (w ? s_axi_bvalid : s_axi_rvalid);
         if (tb) begin
            rq = s_axi_rdata;
            rr = w ? s_axi_bresp : s_axi_rresp;
         end
         @(posedge aclk);
         if (ta) begin
            s_axi_awvalid <= 0;
            s_axi_arvalid <= 0;
            pa = 0;
         end
         if (tw) begin
            s_axi_wvalid <= 0;
            pw = 0;
         end
         if (tb) begin
            s_axi_bready <= 0;
            s_axi_rready <= 0;
            pb = 0;
         end
      end
      if (pb) begin
         bad_count++;
         results();
      end
   endtask
   // ----------------
   // scenarios
   // ----------------
   task t_boot();
      settle(1);
      chk(loop_reset_q, 1);
      chk(sys_reset_n_q, 0);
      chk(det_enable_q, 1);
      chk(loop_enable_q, 1);
      wait_sys();
      chk(lock_out_q, 1);
      xfer(1, 'h0, 'h0);
      chk(rr, 'h0);
      xfer(0, 'h0, 0);
      chk(rq, 'h1);
      xfer(1, 'h40, 'h3);
      chk(rr, 'h2);
      xfer(0, 'h4, 0);
      chk(rq, 'h2);
      xfer(0, 'h40, 0);
      chk(rr, 'h2);
      $display("boot test done");
   endtask
   task t_ctrl();
      xfer(1, 'h4, 'h3);
      settle(2);
      chk(loop_reset_q, 1);
      chk(sys_reset_n_q, 0);
      wait_sys();
      xfer(0, 'h4, 0);
      chk(rq, 'h2);
      xfer(1, 'h4, 'h0);
      settle(2);
      chk(det_enable_q, 0);
      xfer(1, 'h4, 'h2);
      settle(2);
      chk(det_enable_q, 1);
      $display("control test done");
   endtask
   task t_loss();
      @(posedge aclk) drop <= 1;
      settle(8);
      chk(sys_reset_n_q, 0);
      xfer(0, 'h0, 0);
      chk(rq, 'h0);
      @(posedge aclk) drop <= 0;
      wait_sys();
      xfer(0, 'h8, 0);
      chk(rq, 'h3);
      $display("lock loss test done");
   endtask
   task t_pin();
      xfer(1, 'h14, 'h0);
      @(posedge aclk) ext_loop_reset <= 1;
      settle(4);
      chk(loop_reset_q, 1);
      chk(sys_reset_n_q, 0);
      repeat (206) @(posedge aclk);
      ext_loop_reset <= 0;
      wait_sys();
      @(posedge aclk) ext_loop_enable <= 0;
      settle(4);
      chk(loop_enable_q, 0);
      @(posedge aclk) ext_loop_enable <= 1;
      wait_sys();
      @(posedge aclk) loop_phase_done_async <= 1;
      settle(4);
      chk(phase_done_out_q, 1);
      @(posedge aclk) loop_phase_done_async <= 0;
      xfer(1, 'h14, 'h7);
      $display("pin test done");
   endtask
   task t_irq();
      xfer(1, 'h10, 'h7);
      xfer(1, 'hc, 'h4);
      @(posedge aclk) loop_phase_done_async <= 1;
      settle(5);
      chk(irq_q, 1);
      chk(phase_done_out_q, 0);
      xfer(0, 'h0, 0);
      chk(rq, 'h3);
      xfer(1, 'hc, 'h0);
      settle(2);
      chk(irq_q, 0);
      @(posedge aclk) loop_phase_done_async <= 0;
      xfer(1, 'hc, 'h4);
      settle(2);
      chk(irq_q, 1);
      xfer(1, 'h10, 'h7);
      settle(2);
      chk(irq_q, 0);
      xfer(0, 'h8, 0);
      chk(rq, 'h0);
      $display("interrupt test done");
   endtask
   task t_freeze();
      @(posedge aclk) clk_en <= 0;
      loop_phase_done_async <= 1;
      settle(6);
      chk(irq_q, 0);
      @(posedge aclk) clk_en <= 1;
      settle(5);
      chk(irq_q, 1);
      xfer(0, 'h8, 0);
      chk(rq, 'h4);
      @(posedge aclk) loop_phase_done_async <= 0;
      xfer(1, 'h10, 'h7);
      settle(2);
      chk(irq_q, 0);
      $display("freeze test done");
   endtask
   initial begin
      aresetn = 0;
      clk_en = 1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hf;
      {loop_phase_done_async, ext_loop_reset, drop} = '0;
      ext_loop_enable = 1;
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      t_boot();
      t_ctrl();
      t_loss();
      t_pin();
      t_irq();
      t_freeze();
      results();
   end
endmodule
